// ===== core/rsc_pkg.sv
// Constants shared by the synthesizer control block.
// Assumes one 25 MHz reference clock and a synchronous active-low reset.
package rsc_pkg;
  localparam int          RSC_FREQ_W      = 32;
  localparam int          RSC_CODE_W      = 4;
  localparam int          RSC_REFERENCE_DIVIDER_RATIO_W    = 2;
  localparam int          RSC_BOOST_W     = 16;
  localparam int          RSC_SETTLE_NS   = 2000;
  localparam int          RSC_CLK_NS      = 40;
  localparam int          RSC_SETTLE_CYC  = (RSC_SETTLE_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
  localparam logic [7:0]  RSC_SETTLE_CNT  = 8'(RSC_SETTLE_CYC);
  localparam logic [3:0]  RSC_CODE_RST    = 4'h8;
  localparam logic [1:0]  RSC_FLT_EXT     = 2'h0;
  localparam logic [1:0]  RSC_FLT_RST     = 2'h1;
  localparam logic [7:0]  RSC_CPI_RST     = 8'h08;
  typedef enum logic [1:0] {
    RSC_IDLE   = 2'b00,
    RSC_SETTLE = 2'b01,
    RSC_JUDGE  = 2'b10
  } rsc_state_type;
endpackage

// ===== core/rsc_code_mem.sv
// Two-entry store of oscillator range codes, one per carrier setting.
// Assumes writes and reads come from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module rsc_code_mem
  import rsc_pkg::*;
#(
  parameter int W = RSC_CODE_W
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rstn,
  // Write side
  input  wire logic         i_we,
  input  wire logic         i_waddr,
  input  wire logic [W-1:0] i_wdata,
  // Read side
  input  wire logic         i_raddr,
  output logic      [W-1:0] o_rdata
);
  logic [W-1:0] mem_reg [2];
  logic [W-1:0] mem_next [2];
  logic [W-1:0] rdata_reg;
  logic [W-1:0] rdata_next;

  always_comb begin
    mem_next[0] = mem_reg[0];
    mem_next[1] = mem_reg[1];
    if (i_we) begin
      mem_next[i_waddr] = i_wdata;
    end
    rdata_next = mem_reg[i_raddr];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      mem_reg[0] <= RSC_CODE_RST;
      mem_reg[1] <= RSC_CODE_RST;
      rdata_reg  <= RSC_CODE_RST;
    end else begin
      mem_reg   <= mem_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
endmodule
`default_nettype wire

// ===== core/rsc_top.sv
// Synthesizer control: carrier select, oscillator arrangement, loop boost and auto-ranging.
// Assumes only the analog comparator input arrives asynchronously; the other inputs are used unsynchronised.
`timescale 1ns/10ps
`default_nettype none
module rsc_top
  import rsc_pkg::*;
#(
  parameter int FW = RSC_FREQ_W,
  parameter int BW = RSC_BOOST_W
) (
  // Clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rstn,
  // Carrier settings
  input  wire logic [FW-1:0]           i_carrier_setting_a,
  input  wire logic [FW-1:0]           i_carrier_setting_b,
  input  wire logic                    i_carrier_sel_b,
  // Oscillator and divider configuration
  input  wire logic                    i_output_divider_sel,
  input  wire logic [RSC_REFERENCE_DIVIDER_RATIO_W-1:0] i_reference_divider_ratio,
  input  wire logic                    i_external_osc_select,
  input  wire logic                    i_external_inductor_select,
  // Ranging control
  input  wire logic                    i_ranging_go_a,
  input  wire logic                    i_ranging_go_b,
  input  wire logic                    i_osc_too_high,
  // Loop settings
  input  wire logic [1:0]              i_loop_normal_cfg,
  input  wire logic [1:0]              i_loop_fast_cfg,
  input  wire logic [7:0]              i_pump_current_normal,
  input  wire logic [7:0]              i_pump_current_fast,
  input  wire logic                    i_boost_enable,
  input  wire logic [BW-1:0]           i_boost_cycles,
  input  wire logic                    i_synth_start,
  // Synthesizer drive
  output logic      [FW-1:0]           o_carrier_freq,
  output logic                         o_output_divider_sel,
  output logic      [RSC_REFERENCE_DIVIDER_RATIO_W-1:0] o_reference_divider_ratio,
  output logic                         o_osc_internal_core,
  output logic                         o_osc_ext_inductor,
  output logic                         o_osc_external,
  output logic      [RSC_CODE_W-1:0]   o_osc_range_code,
  output logic      [1:0]              o_loop_filter_sel,
  output logic                         o_ext_filter_pin_en,
  output logic      [7:0]              o_pump_current,
  output logic                         o_boost_active,
  // Ranging status
  output logic                         o_ranging_go_a,
  output logic                         o_ranging_go_b,
  output logic                         o_ranging_fault
);
  ////////////////////////////////////////////////////////////////////////////////
  // Comparator input synchroniser.
  logic [1:0] cmp_sync_reg;
  logic [1:0] cmp_sync_next;
  always_comb begin
    cmp_sync_next = {cmp_sync_reg[0], i_osc_too_high};
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cmp_sync_reg <= 2'h0;
    end else begin
      cmp_sync_reg <= cmp_sync_next;
    end
  end
  logic cmp_s;
  assign cmp_s = cmp_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Auto-ranging: binary search over the range code, one bit per step.
  rsc_state_type     state_reg, state_next;
  logic              busy_a_reg, busy_a_next;
  logic              busy_b_reg, busy_b_next;
  logic              fault_reg, fault_next;
  logic [RSC_CODE_W-1:0] trial_reg, trial_next;
  logic [RSC_CODE_W-1:0] bit_reg, bit_next;
  logic [7:0]        settle_reg, settle_next;
  logic              mem_we;
  logic [RSC_CODE_W-1:0] stored_code;
  logic              busy;
  assign busy = busy_a_reg | busy_b_reg;

  always_comb begin
    state_next  = state_reg;
    busy_a_next = busy_a_reg;
    busy_b_next = busy_b_reg;
    fault_next  = fault_reg;
    trial_next  = trial_reg;
    bit_next    = bit_reg;
    settle_next = settle_reg;
    mem_we      = 1'b0;
    case (state_reg)
      RSC_IDLE: begin
        if (i_ranging_go_a || i_ranging_go_b) begin
          busy_a_next = i_ranging_go_a;
          busy_b_next = !i_ranging_go_a && i_ranging_go_b;
          fault_next  = 1'b0;
          trial_next  = RSC_CODE_RST;
          bit_next    = RSC_CODE_RST;
          settle_next = RSC_SETTLE_CNT;
          state_next  = RSC_SETTLE;
        end
      end
      RSC_SETTLE: begin
        // Go requests here are ignored.
        if (settle_reg == 8'h00) begin
          state_next = RSC_JUDGE;
        end else begin
          settle_next = settle_reg - 8'h01;
        end
      end
      RSC_JUDGE: begin
        if (cmp_s) begin
          trial_next = trial_reg & ~bit_reg;
        end
        if (bit_reg == 4'h1) begin
          if (cmp_s) begin
            trial_next = trial_reg & ~bit_reg;
          end
          // Fault when the search ends pinned at either end of the range.
          fault_next  = ((trial_reg & ~(cmp_s ? bit_reg : 4'h0)) == 4'h0) || (trial_reg == 4'hf && !cmp_s);
          mem_we      = 1'b1;
          busy_a_next = 1'b0;
          busy_b_next = 1'b0;
          state_next  = RSC_IDLE;
        end else begin
          bit_next    = bit_reg >> 1;
          trial_next  = (cmp_s ? (trial_reg & ~bit_reg) : trial_reg) | (bit_reg >> 1);
          settle_next = RSC_SETTLE_CNT;
          state_next  = RSC_SETTLE;
        end
      end
      default: begin
        state_next = RSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      state_reg  <= RSC_IDLE;
      busy_a_reg <= 1'b0;
      busy_b_reg <= 1'b0;
      fault_reg  <= 1'b0;
      trial_reg  <= RSC_CODE_RST;
      bit_reg    <= RSC_CODE_RST;
      settle_reg <= 8'h00;
    end else begin
      state_reg  <= state_next;
      busy_a_reg <= busy_a_next;
      busy_b_reg <= busy_b_next;
      fault_reg  <= fault_next;
      trial_reg  <= trial_next;
      bit_reg    <= bit_next;
      settle_reg <= settle_next;
    end
  end

  rsc_code_mem #(
    .W (RSC_CODE_W)
  ) u_code_mem (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_we       (mem_we),
    .i_waddr    (busy_b_reg),
    .i_wdata    (trial_next),
    .i_raddr    (i_carrier_sel_b),
    .o_rdata    (stored_code)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Boost timer and loop setting selection.
  logic [BW-1:0] boost_reg, boost_next;
  logic          start_d_reg, start_d_next;
  always_comb begin
    start_d_next = i_synth_start;
    boost_next   = boost_reg;
    if (i_synth_start && !start_d_reg) begin
      boost_next = i_boost_enable ? i_boost_cycles : '0;
    end else if (boost_reg != '0) begin
      boost_next = boost_reg - BW'(1);
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      boost_reg   <= '0;
      start_d_reg <= 1'b0;
    end else begin
      boost_reg   <= boost_next;
      start_d_reg <= start_d_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  logic [FW-1:0] freq_o_reg, freq_o_next;
  logic [1:0]    flt_o_reg, flt_o_next;
  logic [7:0]    cpi_o_reg, cpi_o_next;
  logic          fast_o_reg, fast_o_next;
  logic [2:0]    osc_o_reg, osc_o_next;
  logic          div_o_reg, div_o_next;
  logic [RSC_REFERENCE_DIVIDER_RATIO_W-1:0] ref_o_reg, ref_o_next;
  logic [RSC_CODE_W-1:0]   code_o_reg, code_o_next;
  logic          pin_o_reg, pin_o_next;
  logic          use_fast;
  assign use_fast = (boost_next != '0);

  always_comb begin
    // During ranging the setting under test drives the loop.
    if (busy) begin
      freq_o_next = busy_b_reg ? i_carrier_setting_b : i_carrier_setting_a;
      code_o_next = trial_reg;
    end else begin
      freq_o_next = i_carrier_sel_b ? i_carrier_setting_b : i_carrier_setting_a;
      code_o_next = stored_code;
    end
    fast_o_next = use_fast;
    flt_o_next  = use_fast ? i_loop_fast_cfg : i_loop_normal_cfg;
    pin_o_next  = (flt_o_next == RSC_FLT_EXT);
    cpi_o_next  = use_fast ? i_pump_current_fast : i_pump_current_normal;
    osc_o_next  = {!i_external_inductor_select && i_external_osc_select,
                   i_external_inductor_select,
                   !i_external_inductor_select && !i_external_osc_select};
    div_o_next  = i_output_divider_sel;
    ref_o_next  = i_reference_divider_ratio;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      freq_o_reg <= '0;
      code_o_reg <= RSC_CODE_RST;
      fast_o_reg <= 1'b0;
      flt_o_reg  <= RSC_FLT_RST;
      pin_o_reg  <= 1'b0;
      cpi_o_reg  <= RSC_CPI_RST;
      osc_o_reg  <= 3'h1;
      div_o_reg  <= 1'b0;
      ref_o_reg  <= '0;
    end else begin
      freq_o_reg <= freq_o_next;
      code_o_reg <= code_o_next;
      fast_o_reg <= fast_o_next;
      flt_o_reg  <= flt_o_next;
      pin_o_reg  <= pin_o_next;
      cpi_o_reg  <= cpi_o_next;
      osc_o_reg  <= osc_o_next;
      div_o_reg  <= div_o_next;
      ref_o_reg  <= ref_o_next;
    end
  end

  assign o_carrier_freq            = freq_o_reg;
  assign o_output_divider_sel      = div_o_reg;
  assign o_reference_divider_ratio = ref_o_reg;
  assign o_osc_external            = osc_o_reg[2];
  assign o_osc_ext_inductor        = osc_o_reg[1];
  assign o_osc_internal_core       = osc_o_reg[0];
  assign o_osc_range_code          = code_o_reg;
  assign o_loop_filter_sel         = flt_o_reg;
  assign o_ext_filter_pin_en       = pin_o_reg;
  assign o_pump_current            = cpi_o_reg;
  assign o_boost_active            = fast_o_reg;
  assign o_ranging_go_a            = busy_a_reg;
  assign o_ranging_go_b            = busy_b_reg;
  assign o_ranging_fault           = fault_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_go_a;
    state_reg == RSC_IDLE && i_ranging_go_a;
  endsequence
  a_go_a_busy: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    s_go_a |=> busy_a_reg && !fault_reg) else $error("ranging A did not start");
  a_go_b_busy: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    state_reg == RSC_IDLE && i_ranging_go_b && !i_ranging_go_a |=> busy_b_reg && !busy_a_reg)
    else $error("ranging B did not start");
  a_busy_ends: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    $rose(busy) |-> ##[1:400] !busy) else $error("ranging never finished");
  a_busy_ignore: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    state_reg == RSC_SETTLE && busy_a_reg |=> busy_a_reg && !busy_b_reg) else $error("busy start not ignored");
  a_fault_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    state_reg == RSC_SETTLE |=> $stable(fault_reg)) else $error("fault changed mid run");
  a_filter_pin: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_ext_filter_pin_en == (o_loop_filter_sel == 2'h0)) else $error("filter pin wrong");
  a_fast_sel: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    use_fast |=> o_pump_current == $past(i_pump_current_fast) && o_boost_active)
    else $error("fast pump not applied");
  a_boost_end: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    boost_reg == BW'(1) && !(i_synth_start && !start_d_reg) |=> boost_reg == '0)
    else $error("boost count wrong");
  a_ext_osc: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
    !i_external_inductor_select && i_external_osc_select |=> o_osc_external)
    else $error("external osc not chosen");
endmodule
`default_nettype wire

// ===== verification/rsc_top_bench.sv
// Self-checking bench for the synthesizer control block: config, loop boost and auto-ranging.
// Assumes the design under core/, a 25 MHz clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module rsc_top_bench;
  import rsc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic        clk = 1'b0, rstn = 1'b0, selb = 1'b0, odiv = 1'b0, xosc = 1'b0, xind = 1'b0;
  logic        go_a = 1'b0, go_b = 1'b0, hi = 1'b0, ben = 1'b0, start = 1'b0;
  logic [31:0] fa = 32'h0, fb = 32'h0, freq;
  logic [1:0]  rdiv = 2'h0, lnorm = 2'h2, lfast = 2'h3, q_rdiv, loop_filter_sel;
  logic [7:0]  pnorm = 8'h3c, pfast = 8'hc3, pump;
  logic [15:0] bcyc = 16'h0;
  logic [3:0]  code, tgt = 4'h0;
  logic        q_odiv, core, ind, ext, pin, bact, busy_a, busy_b, fault;
  int          mismatches = 0, checks_done = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;
  always @(negedge clk) hi <= (code > tgt);
  rsc_top u_rsc_top (
    .i_core_clk(clk), .i_rstn(rstn), .i_carrier_setting_a(fa), .i_carrier_setting_b(fb),
    .i_carrier_sel_b(selb), .i_output_divider_sel(odiv), .i_reference_divider_ratio(rdiv),
    .i_external_osc_select(xosc), .i_external_inductor_select(xind), .i_ranging_go_a(go_a),
    .i_ranging_go_b(go_b), .i_osc_too_high(hi), .i_loop_normal_cfg(lnorm), .i_loop_fast_cfg(lfast),
    .i_pump_current_normal(pnorm), .i_pump_current_fast(pfast), .i_boost_enable(ben),
    .i_boost_cycles(bcyc), .i_synth_start(start), .o_carrier_freq(freq), .o_output_divider_sel(q_odiv),
    .o_reference_divider_ratio(q_rdiv), .o_osc_internal_core(core), .o_osc_ext_inductor(ind),
    .o_osc_external(ext), .o_osc_range_code(code), .o_loop_filter_sel(loop_filter_sel), .o_ext_filter_pin_en(pin),
    .o_pump_current(pump), .o_boost_active(bact), .o_ranging_go_a(busy_a), .o_ranging_go_b(busy_b),
    .o_ranging_fault(fault));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rstn = 1'b0;
    cyc(4);
    chk(freq, 32'h0, "freq reset");
    chk(code, RSC_CODE_RST, "code reset");
    chk(loop_filter_sel, RSC_FLT_RST, "filter reset");
    chk(pump, RSC_CPI_RST, "pump reset");
    chk({core, ind, ext, pin, bact, busy_a, busy_b, fault}, 8'h80, "flags reset");
    rstn = 1'b1;
    $display("test reset done");
  endtask
  task automatic t_config();
    fa = 32'h33ca_c3a0;
    fb = 32'h19d5_5d10;
    cyc(1);
    chk(freq, fa, "carrier a");
    selb = 1'b1;
    cyc(1);
    chk(freq, fb, "carrier b");
    selb = 1'b0;
    for (int i = 0; i < 4; i++) begin
      odiv = i[0];
      rdiv = i[1:0];
      {xind, xosc} = i[1:0];
      cyc(1);
      chk(q_odiv, i[0], "output divider");
      chk(q_rdiv, i[1:0], "reference divider");
      chk({core, ind, ext}, i[1] ? 3'b010 : (i[0] ? 3'b001 : 3'b100), "osc arrangement");
    end
    {xind, xosc} = 2'b00;
    $display("test config done");
  endtask
  task automatic t_filter();
    for (int i = 0; i < 4; i++) begin
      lnorm = i[1:0];
      pnorm = 8'(i * 8'h51);
      cyc(1);
      chk(loop_filter_sel, i[1:0], "normal filter");
      chk(pin, i == 0, "external filter pin");
      chk(pump, pnorm, "normal pump");
    end
    lnorm = 2'h2;
    pnorm = 8'h3c;
    cyc(1);
    $display("test filter done");
  endtask
  task automatic t_boost(input logic en, input logic [15:0] n);
    int k;
    k = 0;
    ben = en;
    bcyc = n;
    start = 1'b1;
    for (int w = 0; w < 4 && bact !== 1'b1; w++) cyc(1);
    while (bact === 1'b1 && k < 1000) begin
      chk(loop_filter_sel, lfast, "fast filter");
      chk(pump, pfast, "fast pump");
      cyc(1);
      k++;
    end
    chk(k, (en && n != 0) ? n : 0, "boost length");
    if (k >= 1000) begin
      close_out();
    end
    chk(loop_filter_sel, lnorm, "filter after boost");
    chk(pump, pnorm, "pump after boost");
    start = 1'b0;
    cyc(2);
    $display("test boost done");
  endtask
  task automatic t_range(input logic b, input logic [3:0] t, input logic [3:0] ec, input logic ef);
    int k;
    tgt = t;
    {go_b, go_a} = b ? 2'b10 : 2'b01;
    cyc(1);
    {go_b, go_a} = b ? 2'b01 : 2'b10;
    chk(b ? busy_b : busy_a, 1'b1, "ranging busy");
    chk(fault, 1'b0, "fault cleared at start");
    cyc(1);
    {go_b, go_a} = 2'b00;
    chk(b ? busy_a : busy_b, 1'b0, "go while busy");
    chk(freq, b ? fb : fa, "ranging carrier");
    for (k = 0; k < 1000 && (busy_a !== 1'b0 || busy_b !== 1'b0); k++) cyc(1);
    if (k == 1000) begin
      mismatches++;
      $display("[FAIL] %0t ranging timeout", $time);
      close_out();
    end
    cyc(1);
    chk({busy_a, busy_b}, 2'b00, "busy cleared");
    chk(fault, ef, "ranging fault");
    selb = b;
    cyc(2);
    chk(code, ec, "stored code");
    selb = 1'b0;
    cyc(1);
    $display("test ranging done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset();
    t_config();
    t_filter();
    t_range(1'b0, 4'hf, 4'hf, 1'b1);
    t_range(1'b0, 4'h5, 4'h5, 1'b0);
    t_range(1'b1, 4'h9, 4'h9, 1'b0);
    t_range(1'b1, 4'h0, 4'h0, 1'b1);
    t_boost(1'b1, 16'h6);
    t_boost(1'b1, 16'h0);
    t_boost(1'b0, 16'h6);
    cyc(1);
    chk(code, 4'h5, "code a kept");
    close_out();
  end
endmodule
`default_nettype wire
